// *** hdl/updown_counter.sv ***
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
// Contract
// - each channel configured independently as one type
// - switch off means simple, else configured type
// - type select 0 circular, 1 linear
// - 32-bit count, signed or unsigned view
// - simple mode counts two-phase, single multiplication
// - fixed input filter, correct to 50 kHz
// - z input never resets, only reported
// - outputs only from manual control values
// - auxiliary inputs only reported as levels
// - status shows channel runs as simple
// - simple mode ignores function configuration
// - overflow/underflow in simple or linear sets flag, freezes count; circular wraps
// - preset or reset clears flags, resumes counting
// - errors reported through status register
// - gate open/close edges, open wins over close level, both edges keep
// - preset edge loads preset value at refresh
// - clear edge resets count at refresh
// - gate closed after reset until opened
module updown_counter #(
  parameter int unsigned refresh_period = updown_counter_pkg::refresh_cycles,
  parameter int unsigned filter_len = updown_counter_pkg::filter_cycles
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // type select switch on the front
  input wire logic type_switch,
  // encoder pins
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic phase_z,
  // auxiliary digital inputs
  input wire logic aux_in0,
  input wire logic aux_in1,
  // digital outputs
  output logic dig_out0,
  output logic dig_out1,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync; // two-stage release of rst_b
  logic rst_n; // synchronised reset used everywhere

  // assert asynchronously, release through two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ---------------------------------------------------------------
  // input filters and refresh divider
  // ---------------------------------------------------------------
  logic [4:0] raw_pins; // a, b, z, in0, in1
  logic [4:0] pins; // filtered levels
  logic tick; // controller refresh enable

  assign raw_pins = {aux_in1, aux_in0, phase_z, phase_b, phase_a};

  // one filter per pin, fixed rate
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_pin
      pin_filter #(
        .stable_cycles(filter_len)
      ) u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .pin(raw_pins[gi]),
        .level(pins[gi])
      );
    end
  endgenerate

  refresh_tick #(
    .period(refresh_period)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] count; // the 32-bit counter value
    logic [31:0] preset; // preset load value
    logic [31:0] control; // type select and manual outputs
    logic [3:0] req; // request levels written by software
    logic [3:0] req_prev; // levels seen in the last cycle
    logic [3:0] pend; // edges waiting for the next refresh
    logic gate; // gate open
    logic ovf; // overflow flag
    logic udf; // underflow flag
    logic a_prev; // phase a at last cycle
    logic type_sw; // switch level after the synchroniser
    logic [1:0] sw_sync; // switch synchroniser
    logic [31:0] rdata; // read data register
    logic out0; // digital output 0
    logic out1; // digital output 1
  } state_t;

  state_t s;
  state_t next_s;

  // ---------------------------------------------------------------
  // derived signals
  // ---------------------------------------------------------------
  updown_counter_pkg::mode_t mode; // current operating type
  logic wr; // apb write in access phase
  logic rd; // apb read in access phase
  logic valid_addr; // address decodes to a register
  logic a_rise; // phase a rising edge
  logic up; // direction of this count
  logic [3:0] edges; // rising edges of request levels
  logic [31:0] status; // status word

  // type decode from switch and select value
  always_comb
  begin
    if (!s.type_sw)
      mode = updown_counter_pkg::mode_simple;
    else if (s.control[updown_counter_pkg::ctl_type_sel] ==
             updown_counter_pkg::type_linear)
      mode = updown_counter_pkg::mode_linear;
    else
      mode = updown_counter_pkg::mode_circular;
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign valid_addr = (paddr == updown_counter_pkg::reg_control) ||
                      (paddr == updown_counter_pkg::reg_requests) ||
                      (paddr == updown_counter_pkg::reg_preset) ||
                      (paddr == updown_counter_pkg::reg_count) ||
                      (paddr == updown_counter_pkg::reg_status);

  // x1 decode: step on a rise, up when b is low (a leads)
  assign a_rise = pins[0] && !s.a_prev;
  assign up = !pins[1];

  // request edges seen against the level of the previous cycle
  assign edges = s.req & ~s.req_prev;

  // status word; flags and levels only
  always_comb
  begin
    status = '0;
    status[updown_counter_pkg::st_ovf] = s.ovf;
    status[updown_counter_pkg::st_udf] = s.udf;
    status[updown_counter_pkg::st_gate] = s.gate;
    status[updown_counter_pkg::st_simple] =
      (mode == updown_counter_pkg::mode_simple);
    status[updown_counter_pkg::st_linear] =
      (mode == updown_counter_pkg::mode_linear);
    status[updown_counter_pkg::st_in0] = pins[3];
    status[updown_counter_pkg::st_in1] = pins[4];
    status[updown_counter_pkg::st_z] = pins[2];
    status[updown_counter_pkg::st_out0] = s.out0;
    status[updown_counter_pkg::st_out1] = s.out1;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.a_prev = pins[0];
    next_s.sw_sync = {s.sw_sync[0], type_switch};
    // switch level follows the synchroniser in every cycle
    if (s.sw_sync[1] != s.type_sw)
      next_s.type_sw = s.sw_sync[1];

    // software writes
    if (wr)
    begin
      unique case (paddr)
        updown_counter_pkg::reg_control:
          next_s.control = pwdata;
        updown_counter_pkg::reg_requests:
          next_s.req = pwdata[3:0];
        updown_counter_pkg::reg_preset:
          next_s.preset = pwdata;
        default:
          next_s.control = s.control;
      endcase
    end

    // edges wait for the next refresh; set wins over the clear
    next_s.pend = s.pend | edges;
    next_s.req_prev = s.req;

    // count pulses while gate open and not frozen
    if (s.gate && a_rise)
    begin
      if (mode == updown_counter_pkg::mode_circular)
        next_s.count = up ? s.count + 32'h0000_0001
                          : s.count - 32'h0000_0001;
      else if (s.ovf || s.udf)
        next_s.count = s.count;
      else if (up && s.count == 32'h7FFF_FFFF)
        next_s.ovf = 1'b1;
      else if (!up && s.count == 32'h8000_0000)
        next_s.udf = 1'b1;
      else
        next_s.count = up ? s.count + 32'h0000_0001
                          : s.count - 32'h0000_0001;
    end

    // refresh: apply pending requests
    if (tick)
    begin
      next_s.pend = edges;
      // open wins over close level; both edges keep gate
      if (s.pend[updown_counter_pkg::req_open] &&
          s.pend[updown_counter_pkg::req_close])
        next_s.gate = s.gate;
      else if (s.pend[updown_counter_pkg::req_open])
        next_s.gate = 1'b1;
      else if (s.pend[updown_counter_pkg::req_close])
        next_s.gate = 1'b0;
      // clear and preset act regardless of gate
      if (s.pend[updown_counter_pkg::req_clear])
      begin
        next_s.count = 32'h0000_0000;
        next_s.ovf = 1'b0;
        next_s.udf = 1'b0;
      end
      else if (s.pend[updown_counter_pkg::req_preset])
      begin
        next_s.count = s.preset;
        next_s.ovf = 1'b0;
        next_s.udf = 1'b0;
      end
      // manual outputs only, in every type
      next_s.out0 = s.control[updown_counter_pkg::ctl_out0];
      next_s.out1 = s.control[updown_counter_pkg::ctl_out1];
    end

    // read data
    next_s.rdata = '0;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        updown_counter_pkg::reg_control:
          next_s.rdata = s.control;
        updown_counter_pkg::reg_requests:
          next_s.rdata = {28'h000_0000, s.req};
        updown_counter_pkg::reg_preset:
          next_s.rdata = s.preset;
        updown_counter_pkg::reg_count:
          next_s.rdata = s.count;
        updown_counter_pkg::reg_status:
          next_s.rdata = status;
        default:
          next_s.rdata = '0;
      endcase
    end
    else if (rd)
    begin
      next_s.rdata = s.rdata;
    end
  end

  // ---------------------------------------------------------------
  // state register; gate closed from reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.control <= updown_counter_pkg::ctl_reset;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dig_out0 = s.out0;
  assign dig_out1 = s.out1;
  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !valid_addr;

endmodule

// *** hdl/updown_counter_pkg.sv ***
package updown_counter_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned clk_freq_hz = 125_000_000;
  // fixed filter rate of the counter inputs
  localparam int unsigned filter_rate_hz = 50_000;
  // shortest pulse half period at the filter rate, in ns
  localparam int unsigned filter_min_ns = 1_000_000_000 / (2 * filter_rate_hz);
  // stable cycles needed before an input change is accepted (round down)
  localparam int unsigned filter_cycles =
    (filter_min_ns * (clk_freq_hz / 1_000_000)) / 1000 / 4;
  // default cycles between two controller refreshes
  localparam int unsigned refresh_cycles = 1250;

  // ---------------------------------------------------------------
  // apb register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] reg_control = 8'h00;
  localparam logic [7:0] reg_requests = 8'h04;
  localparam logic [7:0] reg_preset = 8'h08;
  localparam logic [7:0] reg_count = 8'h0C;
  localparam logic [7:0] reg_status = 8'h10;

  // control register fields
  localparam int unsigned ctl_type_sel = 0;
  localparam int unsigned ctl_out0 = 1;
  localparam int unsigned ctl_out1 = 2;
  localparam logic [31:0] ctl_reset = 32'h0000_0000;

  // request register fields (level, edge sensitive)
  localparam int unsigned req_open = 0;
  localparam int unsigned req_close = 1;
  localparam int unsigned req_preset = 2;
  localparam int unsigned req_clear = 3;

  // status register fields
  localparam int unsigned st_ovf = 0;
  localparam int unsigned st_udf = 1;
  localparam int unsigned st_gate = 2;
  localparam int unsigned st_simple = 3;
  localparam int unsigned st_linear = 4;
  localparam int unsigned st_in0 = 5;
  localparam int unsigned st_in1 = 6;
  localparam int unsigned st_z = 7;
  localparam int unsigned st_out0 = 8;
  localparam int unsigned st_out1 = 9;

  // counter type select values
  localparam logic type_circular = 1'b0;
  localparam logic type_linear = 1'b1;

  // operating type of a channel
  typedef enum logic [1:0] {
    mode_simple = 2'b00,
    mode_circular = 2'b01,
    mode_linear = 2'b11
  } mode_t;

endpackage

// *** hdl/pin_filter.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// three-stage synchroniser with a stability filter
// ---------------------------------------------------------------
module pin_filter #(
  parameter int unsigned stable_cycles = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pin and filtered level
  input wire logic pin,
  output logic level
);

  localparam int unsigned cw = $clog2(stable_cycles + 1);

  typedef struct packed {
    logic [2:0] sync;
    logic [cw-1:0] cnt;
    logic level;
  } state_t;

  state_t s;
  state_t next_s;

  // filter: change counts once stages two and three agree and hold
  always_comb
  begin
    next_s = s;
    next_s.sync = {s.sync[1:0], pin};
    if (s.sync[2] != s.sync[1] || s.sync[2] == s.level)
    begin
      next_s.cnt = '0;
    end
    else if (s.cnt >= cw'(stable_cycles - 1))
    begin
      next_s.level = s.sync[2];
      next_s.cnt = '0;
    end
    else
    begin
      next_s.cnt = s.cnt + cw'(1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign level = s.level;

endmodule

// *** hdl/refresh_tick.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// refresh divider: one-cycle enable every period cycles
// ---------------------------------------------------------------
module refresh_tick #(
  parameter int unsigned period = 1250
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // refresh enable pulse
  output logic tick
);

  localparam int unsigned cw = $clog2(period + 1);

  typedef struct packed {
    logic [cw-1:0] cnt;
    logic tick;
  } state_t;

  state_t s;
  state_t next_s;

  // count down and pulse at wrap
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == '0)
    begin
      next_s.cnt = cw'(period - 1);
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt - cw'(1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;

endmodule

// *** tb/quad_encoder.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// encoder model: two-phase x1 with a z pulse each cycle
// ---------------------------------------------------------------
module quad_encoder #(
  parameter int quarter = 8
) (
  // clock
  input wire logic clk,
  // encoder pins
  output logic pa,
  output logic pb,
  output logic pz
);
  // leading and lagging phase, direction, index
  logic lead = 1'b0, lag = 1'b0, up_dir = 1'b1, zl = 1'b0;
  // up: a leads b; down: b leads a
  assign pa = up_dir ? lead : lag;
  assign pb = up_dir ? lag : lead;
  assign pz = zl;
  // n full cycles, edges a quarter apart; pins idle low after
  task automatic move(input logic up, input int n);
    up_dir <= up;
    repeat (n)
    begin
      repeat (quarter) @(posedge clk);
      lead <= 1'b1;
      repeat (quarter) @(posedge clk);
      lag <= 1'b1;
      zl <= 1'b1;
      repeat (quarter) @(posedge clk);
      lead <= 1'b0;
      zl <= 1'b0;
      repeat (quarter) @(posedge clk);
      lag <= 1'b0;
    end
  endtask
endmodule

// *** tb/updown_counter_props.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker of the up/down counter
// ---------------------------------------------------------------
module updown_counter_props #(
  parameter int unsigned refresh_period = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // manual outputs
  input wire logic dig_out0,
  input wire logic dig_out1,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // time for a control write to reach the outputs
  localparam int unsigned quiet_max = refresh_period + 4;
  // access phase, decode and status read
  logic acc, mapped, st_rd;
  // cycles since the last control write
  logic [15:0] quiet;
  assign acc = psel && penable;
  assign mapped = paddr[1:0] == 2'b00
    && paddr <= updown_counter_pkg::reg_status;
  assign st_rd = acc && !pwrite
    && paddr == updown_counter_pkg::reg_status;
  // saturating counter, cleared by a control write
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      quiet <= '0;
    else if (acc && pwrite && paddr == updown_counter_pkg::reg_control)
      quiet <= '0;
    else if (quiet < 16'(quiet_max))
      quiet <= quiet + 16'd1;

  a_ready_high: assert property (pready)
    else $error("ready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_flags_apart: assert property (st_rd |-> !(prdata[updown_counter_pkg::st_ovf] && prdata[updown_counter_pkg::st_udf]))
    else $error("both range flags set");
  a_mode_apart: assert property (st_rd |-> !(prdata[updown_counter_pkg::st_simple] && prdata[updown_counter_pkg::st_linear]))
    else $error("simple and linear together");
  a_outs_quiet: assert property (quiet == 16'(quiet_max) |-> $stable({dig_out0, dig_out1}))
    else $error("outputs moved without control write");
  a_out_status: assert property (quiet == 16'(quiet_max) && st_rd |-> prdata[updown_counter_pkg::st_out0] == dig_out0 && prdata[updown_counter_pkg::st_out1] == dig_out1)
    else $error("output status differs from pins");
endmodule

bind updown_counter updown_counter_props #(
  .refresh_period(refresh_period)
) chk (
  .clk, .rst_b, .dig_out0, .dig_out1, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr);

// *** tb/updown_counter_tb.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// bench of the up/down counter over apb
// ---------------------------------------------------------------
module updown_counter_tb;
  // short refresh period for a quick run
  localparam int unsigned rp = 8;
  // request masks
  localparam logic [31:0] r_open = 32'h1 << updown_counter_pkg::req_open;
  localparam logic [31:0] r_close = 32'h1 << updown_counter_pkg::req_close;
  localparam logic [31:0] r_pre = 32'h1 << updown_counter_pkg::req_preset;
  localparam logic [31:0] r_clr = 32'h1 << updown_counter_pkg::req_clear;
  // clock, reset and front pins
  logic clk = 1'b0, rst_b = 1'b0, type_switch = 1'b0;
  logic aux_in0 = 1'b0, aux_in1 = 1'b0, dig_out0, dig_out1;
  wire logic pa, pb, pz;
  // apb master side
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic e;
  int errors = 0, tests_run = 0, cycles = 0;

  // 125 mhz clock
  always #4 clk = ~clk;

  updown_counter #(.refresh_period(rp), .filter_len(2)) uut (
    .clk, .rst_b, .type_switch, .phase_a(pa), .phase_b(pb),
    .phase_z(pz), .aux_in0, .aux_in1, .dig_out0, .dig_out1, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  quad_encoder #(.quarter(8)) enc (.clk, .pa, .pb, .pz);

  // ---------------------------------------------------------------
  // checks, closing and watchdog
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] x, g);
    tests_run++;
    if (g !== x)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // apb transfer: setup, then access until ready at an edge
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // request levels, held over several refresh ticks
  task automatic reqw(input logic [31:0] v);
    xfer(1'b1, updown_counter_pkg::reg_requests, v);
    repeat (3 * rp) @(posedge clk);
  endtask
  task automatic pulse(input logic [31:0] v);
    reqw(v);
    reqw(32'h0000_0000);
  endtask
  task automatic preset(input logic [31:0] v);
    xfer(1'b1, updown_counter_pkg::reg_preset, v);
    pulse(r_pre);
  endtask
  // encoder cycles, then time for the filter
  task automatic mv(input logic up, input int n);
    enc.move(up, n);
    repeat (8) @(posedge clk);
  endtask
  task automatic cnt(input logic [31:0] x);
    xfer(1'b0, updown_counter_pkg::reg_count, 32'h0000_0000);
    chk("count", x, q);
  endtask
  task automatic st(input logic [31:0] x);
    xfer(1'b0, updown_counter_pkg::reg_status, 32'h0000_0000);
    chk("status", x, q);
  endtask
  function automatic logic [31:0] bt(input int unsigned n);
    return 32'h0000_0001 << n;
  endfunction
  // simple mode status from flags and gate
  function automatic logic [31:0] sts(input logic ov, ud, gt);
    return (32'(ov) << updown_counter_pkg::st_ovf)
      | (32'(ud) << updown_counter_pkg::st_udf)
      | (32'(gt) << updown_counter_pkg::st_gate)
      | bt(updown_counter_pkg::st_simple);
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // closed gate after reset ignores pulses
    st(sts(1'b0, 1'b0, 1'b0));
    mv(1'b1, 3);
    cnt(32'h0000_0000);
    pulse(r_open);
    st(sts(1'b0, 1'b0, 1'b1));
    mv(1'b1, 5);
    mv(1'b0, 2);
    cnt(32'h0000_0003);
    // both edges at once leave the gate as it is
    pulse(r_open | r_close);
    st(sts(1'b0, 1'b0, 1'b1));
    pulse(r_close);
    mv(1'b1, 2);
    cnt(32'h0000_0003);
    pulse(r_open | r_close);
    st(sts(1'b0, 1'b0, 1'b0));
    // open wins over a held close level
    reqw(r_close);
    pulse(r_open | r_close);
    st(sts(1'b0, 1'b0, 1'b1));
    // preset near the top, overflow and freeze
    preset(32'h7FFF_FFFE);
    cnt(32'h7FFF_FFFE);
    mv(1'b1, 3);
    cnt(32'h7FFF_FFFF);
    st(sts(1'b1, 1'b0, 1'b1));
    mv(1'b0, 1);
    cnt(32'h7FFF_FFFF);
    pulse(r_clr);
    cnt(32'h0000_0000);
    st(sts(1'b0, 1'b0, 1'b1));
    mv(1'b0, 1);
    cnt(32'hFFFF_FFFF);
    // underflow, then preset and clear with the gate closed
    preset(32'h8000_0001);
    mv(1'b0, 2);
    cnt(32'h8000_0000);
    st(sts(1'b0, 1'b1, 1'b1));
    pulse(r_close);
    preset(32'h0000_0005);
    cnt(32'h0000_0005);
    st(sts(1'b0, 1'b0, 1'b0));
    pulse(r_clr);
    cnt(32'h0000_0000);
    // manual outputs and auxiliary levels
    aux_in1 <= 1'b1;
    xfer(1'b1, updown_counter_pkg::reg_control,
      bt(updown_counter_pkg::ctl_out0) | bt(updown_counter_pkg::ctl_out1));
    repeat (3 * rp) @(posedge clk);
    chk("outputs", 32'h0000_0003, {30'h0, dig_out1, dig_out0});
    st(sts(1'b0, 1'b0, 1'b0) | bt(updown_counter_pkg::st_in1)
      | bt(updown_counter_pkg::st_out0)
      | bt(updown_counter_pkg::st_out1));
    // switch on: linear, then circular with a wrap below zero
    type_switch <= 1'b1;
    xfer(1'b1, updown_counter_pkg::reg_control,
      bt(updown_counter_pkg::ctl_type_sel));
    repeat (3 * rp) @(posedge clk);
    st(bt(updown_counter_pkg::st_linear)
      | bt(updown_counter_pkg::st_in1));
    xfer(1'b1, updown_counter_pkg::reg_control, 32'h0000_0000);
    pulse(r_open | r_clr);
    mv(1'b0, 1);
    cnt(32'hFFFF_FFFF);
    st(bt(updown_counter_pkg::st_gate)
      | bt(updown_counter_pkg::st_in1));
    // unmapped address and read-only count
    xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
    chk("slverr", 32'h0000_0001, 32'(e));
    xfer(1'b1, updown_counter_pkg::reg_count, 32'h0000_0000);
    cnt(32'hFFFF_FFFF);
    xfer(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    complete_run();
  end
endmodule
